/* scp_consts.svh */
// Offsets, field positions, reset values and timing counts of the serial ROM port
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define SCP_ADDR_W 8
`define SCP_OFF_PIN 8'h08
`define SCP_OFF_TEST 8'h0C
`define SCP_OFF_RFC 8'h48
`define SCP_OFF_RFD 8'h4C
`define SCP_OFF_IRQ_STAT 8'h80
`define SCP_OFF_IRQ_MASK 8'h84
`define SCP_PIN_RESET 32'h0000_0002
`define SCP_PIN_W 7
`define SCP_B_MGMT_CLK 6
`define SCP_B_MGMT_DIR 5
`define SCP_B_MGMT_DATA 4
`define SCP_B_ROM_CS 3
`define SCP_B_ROM_CLK 2
`define SCP_B_ROM_OUT 1
`define SCP_B_ROM_IN 0
`define SCP_B_RELOAD 2
`define SCP_B_CHECK 1
`define SCP_B_FAIL 0
`define SCP_IRQ_W 3
`define SCP_IRQ_LOAD 0
`define SCP_IRQ_CHECK 1
`define SCP_IRQ_FAIL 2
`define SCP_SYNC_RESET 2'h2
`define SCP_RFC_ADDR_W 10
`define SCP_RFC_SA0 10'h000
`define SCP_RFC_SA1 10'h002
`define SCP_RFC_SA2 10'h004
`define SCP_IMG_WORDS 12
`define SCP_W_INT 4'h2
`define SCP_W_MISC 4'h3
`define SCP_W_SA0 6
`define SCP_W_SA1 7
`define SCP_W_SA2 8
`define SCP_W_SA3 9
`define SCP_W_WAKE 4'hA
`define SCP_W_SUM 4'hB
`define SCP_SUM_SEED 8'h55
`define SCP_RD_OPCODE 3'h6
`define SCP_HDR_BITS 9
`define SCP_LAST_BIT 5'h18
`define SCP_CLK_NS 100
`define SCP_LOAD_US 1500
`define SCP_BITS_PER_WORD 27
`define SCP_HALF_CYC ((`SCP_LOAD_US * 1000 / `SCP_CLK_NS) / (`SCP_IMG_WORDS * `SCP_BITS_PER_WORD * 2))
`endif

/* scp_pkg.sv */
// Types and checksum helper of the serial ROM port
package scp_pkg;
   typedef struct packed {
      logic cs;
      logic sk;
      logic di;
   } scp_rom_pins_t;

   typedef struct packed {
      logic [15:0] int_latency;
      logic [15:0] misc;
      logic [15:0] wake_filter;
   } scp_cfg_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_SETUP = 2'b01,
      RD_BIT = 2'b10,
      RD_END = 2'b11
   } scp_rd_state_t;

   // High plus low byte of one image word, modulo 256
   function automatic logic [7:0] scp_byte_sum(input logic [15:0] w);
      scp_byte_sum = w[15:8] + w[7:0];
   endfunction
endpackage

/* scp_rom_model.sv */
// Serial ROM and management PHY model facing the pin side of the port
`timescale 1ns/100ps
`default_nettype none
module scp_rom_model (
   // Serial ROM pins
   input wire logic rom_cs,
   input wire logic rom_sk,
   input wire logic rom_di,
   output logic rom_do,
   // Management data pin
   input wire logic mgmt_data_o,
   input wire logic mgmt_data_oe,
   input wire logic phy_level,
   output logic mgmt_data_i
);
   logic [15:0] mem [12];
   logic [5:0] adr;
   logic ok;
   int cnt;
   // Pin level is the port's driver when enabled, else the PHY
   assign mgmt_data_i = mgmt_data_oe ? mgmt_data_o : phy_level;
   // image layout; words 0 and 1 are arbitrary
   initial begin
      mem = '{16'h1A2B, 16'h3C4D, 16'h2CD0, 16'hCF82, 16'h0000, 16'h0000,
              16'h0003, 16'h1122, 16'h3344, 16'h5566, 16'hA098, 16'h0055};
      rom_do = 1'b1;
      cnt = 0;
   end
   // Deselected: output released, pull-up reads high
   always @(negedge rom_cs) begin
      cnt = 0;
      rom_do = 1'b1;
   end
   // start bit, read opcode, address, then data MSB first
   always @(posedge rom_sk) begin
      if (rom_cs) begin
         if (cnt < 3)
            ok = (cnt == 0) ? rom_di : ok & (rom_di == (cnt == 1));
         else if (cnt < 9)
            adr = {adr[4:0], rom_di};
         rom_do = (ok && cnt >= 9 && cnt < 25) ? mem[adr][24 - cnt] : 1'b1;
         cnt++;
      end
   end
endmodule
`default_nettype wire

/* scp_rom_reader.sv */
// Reads one 16-bit word from the three-wire serial ROM
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module scp_rom_reader
   import scp_pkg::*;
#(
   parameter int HALF_CYC = `SCP_HALF_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request and answer
   input wire logic start,
   input wire logic [5:0] addr,
   output logic done,
   output logic [15:0] data,
   // ROM pins
   input wire logic rom_do,
   output scp_rom_pins_t pins
);
   localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

   scp_rd_state_t state_q;
   logic [7:0] tick_q;
   logic [8:0] hdr_q;
   logic [4:0] bit_q;
   logic tick_end;

   assign tick_end = (tick_q == HALF_M1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 8'h00;
      end else if (state_q == RD_IDLE || tick_end) begin
         tick_q <= 8'h00;
      end else begin
         tick_q <= tick_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= RD_IDLE;
         hdr_q <= 9'h000;
         bit_q <= 5'h00;
         pins <= '0;
         data <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_q)
            RD_IDLE: begin
               if (start) begin
                  hdr_q <= {`SCP_RD_OPCODE, addr};
                  bit_q <= 5'h00;
                  pins <= '{cs: 1'b1, sk: 1'b0, di: 1'b0};
                  state_q <= RD_SETUP;
               end
            end
            RD_SETUP: begin
               if (tick_end) begin
                  pins.di <= hdr_q[8];
                  hdr_q <= {hdr_q[7:0], 1'b0};
                  state_q <= RD_BIT;
               end
            end
            RD_BIT: begin
               if (tick_end && !pins.sk) begin
                  pins.sk <= 1'b1;
               end else if (tick_end) begin
                  pins.sk <= 1'b0;
                  if (bit_q >= 5'(`SCP_HDR_BITS)) begin
                     data <= {data[14:0], rom_do};
                  end
                  if (bit_q == `SCP_LAST_BIT) begin
                     pins <= '0;
                     state_q <= RD_END;
                  end else begin
                     bit_q <= bit_q + 5'h01;
                     pins.di <= hdr_q[8];
                     hdr_q <= {hdr_q[7:0], 1'b0};
                  end
               end
            end
            RD_END: begin
               if (tick_end) begin
                  done <= 1'b1;
                  state_q <= RD_IDLE;
               end
            end
            default: state_q <= RD_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sk_half_a: assert property ($rose(pins.sk) |-> pins.sk [*8])
      else $error("serial clock high phase too short");
   cs_frame_a: assert property ((state_q == RD_IDLE && start) |=> pins.cs [*8])
      else $error("chip select dropped early in a read");
endmodule
`default_nettype wire

/* scp_serial_rom_port.sv */
// Serial ROM and management pin access port with configuration loader
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module scp_serial_rom_port
   import scp_pkg::*;
#(
   parameter int HALF_CYC = `SCP_HALF_CYC
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SCP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Soft reset pulse
   input wire logic soft_reset,
   // Serial ROM pins
   output logic rom_cs,
   output logic rom_sk,
   output logic rom_di,
   input wire logic rom_do,
   // Management pins
   output logic mgmt_clk,
   output logic mgmt_data_o,
   output logic mgmt_data_oe,
   input wire logic mgmt_data_i,
   // Loaded configuration and interrupt
   output logic [47:0] station_addr,
   output scp_cfg_t cfg,
   output logic irq
);
   logic [`SCP_PIN_W-1:0] pin_q;
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   logic [1:0] lvl_q;
   logic [`SCP_RFC_ADDR_W-1:0] rfc_q;
   logic [`SCP_IRQ_W-1:0] stat_q;
   logic [`SCP_IRQ_W-1:0] mask_q;
   logic [`SCP_IRQ_W-1:0] stat_set;
   logic [`SCP_IRQ_W-1:0] stat_clr;
   logic [15:0] img_q [`SCP_IMG_WORDS];
   logic ld_busy_q;
   logic chk_mode_q;
   logic auto_q;
   logic fail_q;
   logic rd_start_q;
   logic [3:0] word_q;
   logic [7:0] sum_q;
   logic rd_done;
   logic [15:0] rd_data;
   scp_rom_pins_t rd_pins;
   logic [31:0] rdata_d;
   logic err_d;
   logic commit;
   logic wr_pin;
   logic wr_test;
   logic wr_rfc;
   logic wr_rfd;
   logic wr_stat;
   logic wr_mask;
   logic req_load;
   logic req_check;
   logic final_word;
   logic sum_ok;
   logic [31:0] pin_view;

   function automatic logic hit(input logic [`SCP_ADDR_W-1:0] a,
                                input logic [`SCP_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Pin inputs: three flops, level moves when second and third agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= `SCP_SYNC_RESET;
         s2_q <= `SCP_SYNC_RESET;
         s3_q <= `SCP_SYNC_RESET;
         lvl_q <= `SCP_SYNC_RESET;
      end else begin
         s1_q <= {rom_do, mgmt_data_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   // APB access: one wait state, answer on second access cycle
   assign commit = psel && penable && pready;
   assign wr_pin = commit && pwrite && hit(paddr, `SCP_OFF_PIN);
   assign wr_test = commit && pwrite && hit(paddr, `SCP_OFF_TEST);
   assign wr_rfc = commit && pwrite && hit(paddr, `SCP_OFF_RFC);
   assign wr_rfd = commit && pwrite && hit(paddr, `SCP_OFF_RFD);
   assign wr_stat = commit && pwrite && hit(paddr, `SCP_OFF_IRQ_STAT);
   assign wr_mask = commit && pwrite && hit(paddr, `SCP_OFF_IRQ_MASK);

   // released pin reads back live level
   // data-out bit comes from the pin only
   assign pin_view = {25'h0000000, pin_q[`SCP_B_MGMT_CLK], pin_q[`SCP_B_MGMT_DIR],
                      pin_q[`SCP_B_MGMT_DIR] ? pin_q[`SCP_B_MGMT_DATA] : lvl_q[0],
                      pin_q[`SCP_B_ROM_CS], pin_q[`SCP_B_ROM_CLK], lvl_q[1],
                      pin_q[`SCP_B_ROM_IN]};

   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      if (hit(paddr, `SCP_OFF_PIN)) begin
         rdata_d = pin_view;
      end else if (hit(paddr, `SCP_OFF_TEST)) begin
         rdata_d[`SCP_B_RELOAD] = ld_busy_q && !chk_mode_q;
         rdata_d[`SCP_B_CHECK] = ld_busy_q && chk_mode_q;
         rdata_d[`SCP_B_FAIL] = fail_q;
      end else if (hit(paddr, `SCP_OFF_RFC)) begin
         rdata_d[`SCP_RFC_ADDR_W-1:0] = rfc_q;
      end else if (hit(paddr, `SCP_OFF_RFD)) begin
         // station address word by filter address
         if (rfc_q == `SCP_RFC_SA0) begin
            rdata_d[15:0] = station_addr[15:0];
         end else if (rfc_q == `SCP_RFC_SA1) begin
            rdata_d[15:0] = station_addr[31:16];
         end else if (rfc_q == `SCP_RFC_SA2) begin
            rdata_d[15:0] = station_addr[47:32];
         end
      end else if (hit(paddr, `SCP_OFF_IRQ_STAT)) begin
         rdata_d[`SCP_IRQ_W-1:0] = stat_q;
      end else if (hit(paddr, `SCP_OFF_IRQ_MASK)) begin
         rdata_d[`SCP_IRQ_W-1:0] = mask_q;
      end else begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr <= err_d;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Pin access register; bit 1 is never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= '0;
      end else if (soft_reset) begin
         // soft reset back to reset image
         pin_q <= '0;
      end else if (wr_pin) begin
         pin_q <= pwdata[`SCP_PIN_W-1:0] & ~(7'h01 << `SCP_B_ROM_OUT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rfc_q <= '0;
      end else if (soft_reset) begin
         rfc_q <= '0;
      end else if (wr_rfc) begin
         rfc_q <= pwdata[`SCP_RFC_ADDR_W-1:0];
      end
   end

   // Pin drivers, all from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_cs <= 1'b0;
         rom_sk <= 1'b0;
         rom_di <= 1'b0;
         mgmt_clk <= 1'b0;
         mgmt_data_o <= 1'b0;
         mgmt_data_oe <= 1'b0;
      end else begin
         // loader owns ROM pins while busy
         rom_cs <= ld_busy_q ? rd_pins.cs : pin_q[`SCP_B_ROM_CS];
         rom_sk <= ld_busy_q ? rd_pins.sk : pin_q[`SCP_B_ROM_CLK];
         rom_di <= ld_busy_q ? rd_pins.di : pin_q[`SCP_B_ROM_IN];
         mgmt_clk <= pin_q[`SCP_B_MGMT_CLK];
         mgmt_data_oe <= pin_q[`SCP_B_MGMT_DIR];
         mgmt_data_o <= pin_q[`SCP_B_MGMT_DATA];
      end
   end

   // Load sequencer
   assign req_load = wr_test && pwdata[`SCP_B_RELOAD];
   assign req_check = wr_test && pwdata[`SCP_B_CHECK];
   assign final_word = ld_busy_q && rd_done && (word_q == `SCP_W_SUM);
   // low byte 55h, high byte negated sum
   assign sum_ok = (rd_data[7:0] == `SCP_SUM_SEED) && (rd_data[15:8] == 8'(8'h00 - sum_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_busy_q <= 1'b0;
         chk_mode_q <= 1'b0;
         auto_q <= 1'b1;
         word_q <= 4'h0;
         sum_q <= 8'h00;
         rd_start_q <= 1'b0;
      end else begin
         rd_start_q <= 1'b0;
         if (!ld_busy_q && (auto_q || req_load || req_check)) begin
            ld_busy_q <= 1'b1;
            chk_mode_q <= !(auto_q || req_load);
            auto_q <= 1'b0;
            word_q <= 4'h0;
            sum_q <= `SCP_SUM_SEED;
            rd_start_q <= 1'b1;
         end else if (ld_busy_q && rd_done) begin
            if (word_q == `SCP_W_SUM) begin
               ld_busy_q <= 1'b0;
            end else begin
               sum_q <= sum_q + scp_byte_sum(rd_data);
               word_q <= word_q + 4'h1;
               rd_start_q <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (ld_busy_q && rd_done) begin
         img_q[word_q] <= rd_data;
      end
   end

   // Apply image only after a full load with a good checksum
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
      end else if (final_word && !chk_mode_q && sum_ok) begin
         cfg.int_latency <= img_q[`SCP_W_INT];
         cfg.misc <= img_q[`SCP_W_MISC];
         cfg.wake_filter <= img_q[`SCP_W_WAKE] & 16'hFFF8;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         station_addr <= 48'h0000_0000_0000;
      end else if (final_word && !chk_mode_q && sum_ok) begin
         // bit 0 is top of word 6, then words 7 to 9 MSB first
         station_addr[0] <= img_q[`SCP_W_SA0][15];
         for (int i = 0; i < 16; i++) begin
            station_addr[1 + i] <= img_q[`SCP_W_SA1][15 - i];
            station_addr[17 + i] <= img_q[`SCP_W_SA2][15 - i];
         end
         for (int i = 0; i < 15; i++) begin
            station_addr[33 + i] <= img_q[`SCP_W_SA3][15 - i];
         end
      end else if (wr_rfd) begin
         // software write of one address word
         if (rfc_q == `SCP_RFC_SA0) begin
            station_addr[15:0] <= pwdata[15:0];
         end else if (rfc_q == `SCP_RFC_SA1) begin
            station_addr[31:16] <= pwdata[15:0];
         end else if (rfc_q == `SCP_RFC_SA2) begin
            station_addr[47:32] <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q <= 1'b0;
      end else if (soft_reset) begin
         fail_q <= 1'b0;
      end else if (final_word && chk_mode_q) begin
         fail_q <= !sum_ok;
      end else if (!ld_busy_q && req_check && !req_load) begin
         fail_q <= 1'b0;
      end
   end

   // Interrupts: sticky, write one to clear, set wins
   assign stat_set[`SCP_IRQ_LOAD] = final_word && !chk_mode_q;
   assign stat_set[`SCP_IRQ_CHECK] = final_word && chk_mode_q;
   assign stat_set[`SCP_IRQ_FAIL] = final_word && chk_mode_q && !sum_ok;
   assign stat_clr = wr_stat ? pwdata[`SCP_IRQ_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
         mask_q <= '0;
         irq <= 1'b0;
      end else if (soft_reset) begin
         stat_q <= stat_set;
         mask_q <= '0;
         irq <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
         if (wr_mask) begin
            mask_q <= pwdata[`SCP_IRQ_W-1:0];
         end
         irq <= |(stat_q & mask_q);
      end
   end

   scp_rom_reader #(
      .HALF_CYC(HALF_CYC)
   ) u_reader (
      .pclk(pclk),
      .presetn(presetn),
      .start(rd_start_q),
      .addr({2'b00, word_q}),
      .done(rd_done),
      .data(rd_data),
      .rom_do(lvl_q[1]),
      .pins(rd_pins)
   );

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || soft_reset);

   sequence pin_write_s;
      wr_pin ##1 !wr_pin;
   endsequence

   sequence pin_read_s;
      commit && !pwrite && hit(paddr, `SCP_OFF_PIN);
   endsequence

   mgmt_clk_a: assert property (pin_write_s |-> ##1 mgmt_clk == $past(pwdata[6], 2))
      else $error("management clock does not follow written bit");
   mgmt_dir_a: assert property (pin_write_s |-> ##1 mgmt_data_oe == $past(pwdata[5], 2))
      else $error("management driver enable does not follow bit");
   mgmt_read_a: assert property ((pin_read_s and !pin_q[5]) |-> prdata[4] == $past(lvl_q[0]))
      else $error("released management data read wrong");
   rom_cs_a: assert property (!ld_busy_q |=> rom_cs == $past(pin_q[3]))
      else $error("chip select not from register");
   rom_sk_a: assert property (!ld_busy_q && $stable(pin_q) |=> $stable(rom_sk))
      else $error("serial clock moved without a write");
   rom_out_a: assert property (pin_read_s |-> prdata[1] == $past(lvl_q[1]))
      else $error("data-out bit not the pin level");
   rom_di_a: assert property (!ld_busy_q |=> rom_di == $past(pin_q[0]))
      else $error("data-in pin not from register");
   upper_zero_a: assert property (pin_read_s |-> prdata[31:7] == 25'h0000000)
      else $error("unused pin register bits not zero");
   reload_busy_a: assert property (rd_start_q && !chk_mode_q && word_q == 4'h0
                                   |-> ld_busy_q [*8])
      else $error("reload not shown busy");
   check_cfg_a: assert property (ld_busy_q && chk_mode_q |=> $stable(cfg))
      else $error("self-check changed configuration");
   check_fail_a: assert property (final_word && chk_mode_q && !sum_ok |=> fail_q)
      else $error("bad checksum not flagged");
   loader_pins_a: assert property (ld_busy_q |=> rom_sk == $past(rd_pins.sk))
      else $error("loader does not own serial clock");
endmodule
`default_nettype wire

/* serial_eeprom_config_port_bench.sv */
// Self-checking bench of the serial ROM and management pin port
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_config_port_bench;
   import scp_pkg::*;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, soft_reset = 1'b0, phy_level = 1'b0, err;
   logic rom_cs, rom_sk, rom_di, rom_do, mgmt_clk, mgmt_data_o, mgmt_data_oe, mgmt_data_i, irq;
   logic [47:0] station_addr, e;
   logic [31:0] r;
   logic [15:0] w;
   scp_cfg_t cfg;
   int n_mismatch = 0, n_compared = 0;

   scp_serial_rom_port #(.HALF_CYC(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .rom_cs(rom_cs),
      .rom_sk(rom_sk), .rom_di(rom_di), .rom_do(rom_do), .mgmt_clk(mgmt_clk),
      .mgmt_data_o(mgmt_data_o), .mgmt_data_oe(mgmt_data_oe), .mgmt_data_i(mgmt_data_i),
      .station_addr(station_addr), .cfg(cfg), .irq(irq));
   scp_rom_model rom (.rom_cs(rom_cs), .rom_sk(rom_sk), .rom_di(rom_di), .rom_do(rom_do),
      .mgmt_data_o(mgmt_data_o), .mgmt_data_oe(mgmt_data_oe), .phy_level(phy_level),
      .mgmt_data_i(mgmt_data_i));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task conclude;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         conclude();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r);
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, r);
      chk(nm, r, exp);
   endtask

   // Polls until reload and self-check have both finished
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h0C, 32'h0, r);
         n++;
      end while (r[2:1] !== 2'b00 && n < 3000);
      if (n >= 3000) begin
         n_mismatch++;
         conclude();
      end
   endtask

   // checksum word over image words 0 to 10
   function automatic logic [15:0] csum();
      logic [7:0] s;
      s = 8'h55;
      for (int i = 0; i < 11; i++)
         s += rom.mem[i][15:8] + rom.mem[i][7:0];
      return {8'h00 - s, 8'h55};
   endfunction

   // Address bit 0 is the top bit of word 6
   function automatic logic [47:0] exp_sa();
      logic [47:0] s;
      logic [47:0] f;
      s = {rom.mem[6][15], rom.mem[7], rom.mem[8], rom.mem[9][15:1]};
      for (int i = 0; i < 48; i++)
         f[i] = s[47 - i];
      return f;
   endfunction

   // Bit-banged read frame: cs is bit 3, clock bit 2, data-in bit 0
   task automatic sw_read(input logic [5:0] a, output logic [15:0] d);
      logic [8:0] h;
      h = {3'b110, a};
      for (int i = 8; i >= 0; i--) begin
         wr(8'h08, {28'h0, 3'b100, h[i]});
         wr(8'h08, {28'h0, 3'b110, h[i]});
      end
      for (int i = 0; i < 16; i++) begin
         wr(8'h08, 32'h8);
         wr(8'h08, 32'hC);
         repeat (6) @(posedge pclk);
         apb(1'b0, 8'h08, 32'h0, r);
         d = {d[14:0], r[1]};
      end
      wr(8'h08, 32'h0);
   endtask

   initial begin
      #1 rom.mem[11] = csum();
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle();
      chk("cfg", cfg, {rom.mem[2], rom.mem[3], rom.mem[10] & 16'hFFF8});
      chk("station", station_addr, exp_sa());
      rdc("pin reset", 8'h08, 32'h2);
      rdc("status", 8'h80, 32'h1);
      chk("irq masked", irq, 1'b0);
      wr(8'h84, 32'h7);
      repeat (3) @(negedge pclk);
      chk("irq", irq, 1'b1);
      wr(8'h80, 32'h1);
      repeat (3) @(negedge pclk);
      chk("irq clear", irq, 1'b0);
      wr(8'h08, 32'hFFFF_FFFF);
      repeat (4) @(negedge pclk);
      chk("pins", {mgmt_clk, mgmt_data_oe, mgmt_data_o, rom_cs, rom_sk, rom_di}, 6'h3F);
      rdc("pin all", 8'h08, 32'h7F);
      wr(8'h08, 32'h0);
      phy_level <= 1'b1;
      repeat (6) @(negedge pclk);
      chk("released", {mgmt_data_oe, mgmt_clk, rom_cs}, 3'h0);
      rdc("mdio in", 8'h08, 32'h12);
      phy_level <= 1'b0;
      wr(8'h08, 32'h79);
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      repeat (4) @(negedge pclk);
      rdc("pin soft", 8'h08, 32'h2);
      sw_read(6'd2, w);
      chk("sw read", w, rom.mem[2]);
      rom.mem[4] = 16'h0001;
      wr(8'h0C, 32'h2);
      wait_idle();
      rdc("fail", 8'h0C, 32'h1);
      rdc("check status", 8'h80, 32'h6);
      chk("sa kept", station_addr, exp_sa());
      wr(8'h80, 32'h7);
      rom.mem[4] = 16'h0000;
      rom.mem[7] = 16'hBEEF;
      rom.mem[11] = csum();
      wr(8'h0C, 32'h4);
      rdc("loading", 8'h0C, 32'h5);
      wait_idle();
      e = exp_sa();
      chk("sa reload", station_addr, e);
      wr(8'h48, 32'h0);
      rdc("filter low", 8'h4C, {16'h0, e[15:0]});
      wr(8'h48, 32'h4);
      rdc("filter high", 8'h4C, {16'h0, e[47:32]});
      wr(8'h48, 32'h2);
      rdc("filter data", 8'h4C, {16'h0, e[31:16]});
      wr(8'h4C, 32'hA5A5);
      repeat (2) @(negedge pclk);
      chk("sa write", station_addr[31:16], 16'hA5A5);
      apb(1'b0, 8'h40, 32'h0, r);
      chk("unmapped", {err, r}, {1'b1, 32'h0});
      conclude();
   end
endmodule
`default_nettype wire
